//--- logic/led_drv_pkg.sv
/*
 * Shared constants and carrier types for the write-only LED driver target.
 * Assumes a single design top that imports the whole package.
 */
package led_drv_pkg;

    // ------------------------------------------------------------
    // serial target address
    // ------------------------------------------------------------
    localparam logic [4:0] TGT_ADDR_HI   = 5'h0f;   // fixed upper bits 01111
    localparam logic [3:0] BYTE_BITS     = 4'h8;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SHUTDOWN  = 8'h00;
    localparam logic [7:0] OFS_DUTY_BASE = 8'h05;
    localparam logic [7:0] OFS_UPDATE    = 8'h25;
    localparam logic [7:0] OFS_CTRL_BASE = 8'h2a;
    localparam logic [7:0] OFS_GLOBAL    = 8'h4a;
    localparam logic [7:0] OFS_RESET     = 8'h4f;
    localparam logic [7:0] CH_COUNT      = 8'h1c;   // 28 channels
    localparam logic [7:0] TRIGGER_VALUE = 8'h00;   // update and reset key

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DUTY_RST      = 8'h00;
    localparam logic       SHUTDOWN_RST  = 1'b0;
    localparam logic       GLOBAL_RST    = 1'b0;
    localparam logic [1:0] SCALE_RST     = 2'h0;
    localparam logic       CH_ON_RST     = 1'b0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] data;
    } reg_write_t;

    typedef struct packed {
        logic [1:0] scale;   // 00 full, 01 half, 10 third, 11 quarter
        logic       on;
    } chan_ctrl_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_DATA,
        ST_SKIP
    } link_state_t;

endpackage : led_drv_pkg

//--- logic/led_pwm_target.sv
/*
 * Write-only serial target with staged LED duty and channel control registers,
 * plus the PWM output stage for 28 channels.
 * Assumes link_clk is a free-running sampling clock well above the bus rate,
 * and that the open-drain data wire is resolved outside from sda_oe.
 */
`timescale 1ns/1ps

// Notes on behaviour
// RULE1 - only writes; address byte with direction bit one is never acknowledged
// RULE2 - target address upper five bits are 01111, bits two and one from strap
// RULE3 - strap to ground 00, supply 11, clock line 01, data line 10
// RULE4 - host keeps the serial clock at or below 400kHz
// RULE5 - data sampled while clock high; data line idles high
// RULE6 - data falling with clock high is a start; address byte follows
// RULE7 - host sends address byte msb first, stable while clock high
// RULE8 - on address match, data held low across the ninth clock pulse
// RULE9 - host stops and abandons transfer when not acknowledged
// RULE10 - register pointer byte follows address and is acknowledged
// RULE11 - every data byte is received msb first and acknowledged
// RULE12 - data rising with clock high is a stop, ending the transfer
// RULE13 - pointer increments by one during each data byte acknowledge
// RULE14 - offset 00h bit zero is software shutdown, resets to zero
// RULE15 - offsets 05h to 20h hold 28 duty bytes, reset zero
// RULE16 - average output is set current times duty over 256
// RULE17 - write to 25h moves staged duty and control into active set
// RULE18 - offsets 2Ah to 45h hold channel enable and current scale
// RULE19 - offset 4Ah is one global control, resets to zero
// RULE20 - write to 4Fh returns every register to its default
// RULE21 - staged values go active only when zero is written to update
// RULE22 - control bit zero turns channel on; bits two to one pick scale
// RULE23 - global bit zero set forces every channel off
// RULE24 - writing zero to reset register restores defaults; also at power-up
// RULE25 - shutdown bit zero means shut down, one means normal
// RULE26 - free-running 8-bit counter; output on for duty counts of 256
module led_pwm_target
    import led_drv_pkg::*;
(
    // clocks and reset
    input  wire logic        mclk,
    input  wire logic        link_clk,
    input  wire logic        sys_rst,
    // serial pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic        addr_sel_pin,
    // hardware shutdown
    input  wire logic        hw_shutdown_pin_n,
    // led side
    output logic [27:0]      led_channel_outputs,
    output logic [55:0]      current_scale_sel
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic in_block(input logic [7:0] a, input logic [7:0] base);
        in_block = (a >= base) && (a < 8'(base + CH_COUNT));
    endfunction : in_block

    function automatic logic [4:0] chan_of(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] d;
        d       = 8'(a - base);
        chan_of = d[4:0];
    endfunction : chan_of

    // ------------------------------------------------------------
    // link domain: pin synchronisers
    // ------------------------------------------------------------
    logic [2:0]  scl_s, sda_s, sel_s;
    logic        scl_f, sda_f, sel_f, scl_p, sda_p;

    // three stages; a change counts once stages two and three agree
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            sel_s <= 3'h0;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            sel_f <= 1'b0;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
            sel_s <= {sel_s[1:0], addr_sel_pin};
            if (scl_s[1] == scl_s[2]) scl_f <= scl_s[2];
            if (sda_s[1] == sda_s[2]) sda_f <= sda_s[2];
            if (sel_s[1] == sel_s[2]) sel_f <= sel_s[2];
            scl_p <= scl_f;
            sda_p <= sda_f;
        end
    end

    logic start_det, stop_det, scl_rise, scl_fall;
    assign start_det = scl_f && scl_p && sda_p && !sda_f;   // RULE6
    assign stop_det  = scl_f && scl_p && !sda_p && sda_f;   // RULE12
    assign scl_rise  = scl_f && !scl_p;
    assign scl_fall  = !scl_f && scl_p;

    // ------------------------------------------------------------
    // link domain: strap decode
    // ------------------------------------------------------------
    logic       sel_idle, sel_start, sel_low;
    logic [1:0] strap_bits;
    link_state_t state;
    logic [3:0]  bit_cnt;

    // a pin tied to a bus line is told apart by watching it around the start
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_idle  <= 1'b0;
            sel_start <= 1'b0;
            sel_low   <= 1'b0;
        end else begin
            if (state == ST_IDLE && !start_det) sel_idle <= sel_f;
            if (start_det) sel_start <= sel_f;
            if (state == ST_ADDR && bit_cnt == 4'h0 && scl_fall) sel_low <= sel_f;
        end
    end

    // ground 00, data line 10, clock line 01, supply 11
    always_comb begin
        if (!sel_idle)       strap_bits = 2'b00;   // RULE3
        else if (!sel_start) strap_bits = 2'b10;   // RULE3
        else if (!sel_low)   strap_bits = 2'b01;   // RULE3
        else                 strap_bits = 2'b11;   // RULE3
    end

    // ------------------------------------------------------------
    // link domain: byte engine
    // ------------------------------------------------------------
    logic [7:0]  shreg, reg_ptr;
    logic        acking, byte_done, addr_hit;
    reg_write_t  wr_evt;
    logic        wr_tgl;

    assign byte_done = scl_fall && bit_cnt == BYTE_BITS && !acking;
    assign addr_hit  = shreg == {TGT_ADDR_HI, strap_bits, 1'b0};   // RULE2 RULE1

    // bits shift on the clock rise, acknowledge turns on and off at falls
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state   <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg   <= 8'h00;
            reg_ptr <= 8'h00;
            acking  <= 1'b0;
            sda_oe  <= 1'b0;
            wr_evt  <= '0;
            wr_tgl  <= 1'b0;
        end else if (start_det) begin
            state   <= ST_ADDR;   // RULE6
            bit_cnt <= 4'h0;
            acking  <= 1'b0;
            sda_oe  <= 1'b0;
        end else if (stop_det) begin
            state   <= ST_IDLE;   // RULE12
            acking  <= 1'b0;
            sda_oe  <= 1'b0;
        end else if (state != ST_IDLE && state != ST_SKIP) begin
            if (scl_rise && bit_cnt != BYTE_BITS) begin
                shreg   <= {shreg[6:0], sda_f};   // RULE5
                bit_cnt <= 4'(bit_cnt + 4'h1);
            end else if (scl_fall && acking) begin
                acking  <= 1'b0;
                sda_oe  <= 1'b0;
                bit_cnt <= 4'h0;
            end else if (byte_done) begin
                case (state)
                    ST_ADDR: begin
                        if (addr_hit) begin
                            state  <= ST_PTR;
                            acking <= 1'b1;   // RULE8
                            sda_oe <= 1'b1;   // RULE8
                        end else begin
                            state  <= ST_SKIP;   // RULE1
                        end
                    end
                    ST_PTR: begin
                        reg_ptr <= shreg;
                        state   <= ST_DATA;
                        acking  <= 1'b1;   // RULE10
                        sda_oe  <= 1'b1;   // RULE10
                    end
                    ST_DATA: begin
                        wr_evt  <= '{ptr: reg_ptr, data: shreg};
                        wr_tgl  <= !wr_tgl;
                        reg_ptr <= 8'(reg_ptr + 8'h01);   // RULE13
                        acking  <= 1'b1;   // RULE11
                        sda_oe  <= 1'b1;   // RULE11
                    end
                    default: state <= ST_SKIP;
                endcase
            end
        end
    end

    // open-drain: the wire is only ever pulled low
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) sda_out <= 1'b0;
        else         sda_out <= 1'b0;
    end

    // ------------------------------------------------------------
    // crossing into mclk: toggle event, data held stable
    // ------------------------------------------------------------
    // wr_evt stays put for a whole byte time, far longer than the sync delay
    logic [2:0] tgl_s, sdb_s;
    logic       tgl_f, tgl_d, sdb_f, wr_fire;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tgl_s <= 3'h0;
            tgl_f <= 1'b0;
            tgl_d <= 1'b0;
            sdb_s <= 3'h0;
            sdb_f <= 1'b0;
        end else begin
            tgl_s <= {tgl_s[1:0], wr_tgl};
            sdb_s <= {sdb_s[1:0], hw_shutdown_pin_n};
            if (tgl_s[1] == tgl_s[2]) tgl_f <= tgl_s[2];
            if (sdb_s[1] == sdb_s[2]) sdb_f <= sdb_s[2];
            tgl_d <= tgl_f;
        end
    end
    assign wr_fire = tgl_f ^ tgl_d;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic       soft_shutdown_bit, global_off, soft_rst, do_update;
    logic [7:0] staged_duty [28];
    logic [7:0] active_duty [28];
    chan_ctrl_t staged_ctrl [28];
    chan_ctrl_t active_ctrl [28];

    assign soft_rst  = wr_fire && wr_evt.ptr == OFS_RESET && wr_evt.data == TRIGGER_VALUE;   // RULE24
    assign do_update = wr_fire && wr_evt.ptr == OFS_UPDATE && wr_evt.data == TRIGGER_VALUE;  // RULE21

    // single control bits
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            soft_shutdown_bit <= SHUTDOWN_RST;   // RULE14
            global_off        <= GLOBAL_RST;     // RULE19
        end else if (soft_rst) begin
            soft_shutdown_bit <= SHUTDOWN_RST;   // RULE20
            global_off        <= GLOBAL_RST;     // RULE20
        end else if (wr_fire) begin
            if (wr_evt.ptr == OFS_SHUTDOWN) soft_shutdown_bit <= wr_evt.data[0];   // RULE14
            if (wr_evt.ptr == OFS_GLOBAL)   global_off        <= wr_evt.data[0];   // RULE19
        end
    end

    // staging copies, written by the bus and invisible to the outputs
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 28; i++) begin
                staged_duty[i] <= DUTY_RST;
                staged_ctrl[i] <= '{scale: SCALE_RST, on: CH_ON_RST};
            end
        end else if (soft_rst) begin
            for (int i = 0; i < 28; i++) begin
                staged_duty[i] <= DUTY_RST;   // RULE20
                staged_ctrl[i] <= '{scale: SCALE_RST, on: CH_ON_RST};
            end
        end else if (wr_fire) begin
            if (in_block(wr_evt.ptr, OFS_DUTY_BASE))   // RULE15
                staged_duty[chan_of(wr_evt.ptr, OFS_DUTY_BASE)] <= wr_evt.data;
            if (in_block(wr_evt.ptr, OFS_CTRL_BASE))   // RULE18
                staged_ctrl[chan_of(wr_evt.ptr, OFS_CTRL_BASE)] <= chan_ctrl_t'(wr_evt.data[2:0]);   // RULE22
        end
    end

    // active copies, loaded by the update key and cleared by the reset key
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 28; i++) begin
                active_duty[i] <= DUTY_RST;
                active_ctrl[i] <= '{scale: SCALE_RST, on: CH_ON_RST};
            end
        end else if (soft_rst) begin
            for (int i = 0; i < 28; i++) begin
                active_duty[i] <= DUTY_RST;   // RULE20
                active_ctrl[i] <= '{scale: SCALE_RST, on: CH_ON_RST};
            end
        end else if (do_update) begin
            for (int i = 0; i < 28; i++) begin
                active_duty[i] <= staged_duty[i];   // RULE17
                active_ctrl[i] <= staged_ctrl[i];   // RULE17
            end
        end
    end

    // ------------------------------------------------------------
    // pwm output stage
    // ------------------------------------------------------------
    logic [7:0] pwm_cnt;

    // duty 0 never lights, 255 lights 255 of 256 counts
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pwm_cnt             <= 8'h00;
            led_channel_outputs <= 28'h0000000;
            current_scale_sel   <= 56'h0;
        end else begin
            pwm_cnt <= 8'(pwm_cnt + 8'h01);   // RULE26
            for (int i = 0; i < 28; i++) begin
                led_channel_outputs[i] <= sdb_f && soft_shutdown_bit && !global_off   // RULE25 RULE23
                    && active_ctrl[i].on && (pwm_cnt < active_duty[i]);              // RULE16 RULE22
                current_scale_sel[2*i +: 2] <= active_ctrl[i].scale;                  // RULE22
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_START_ARMS: assert property (@(posedge link_clk) disable iff (sys_rst)   // RULE6
        start_det |=> state == ST_ADDR && bit_cnt == 4'h0 && !sda_oe)
        else $error("start did not arm address phase");
    AST_STOP_ENDS: assert property (@(posedge link_clk) disable iff (sys_rst)   // RULE12
        stop_det |=> state == ST_IDLE && !sda_oe)
        else $error("stop did not end transfer");
    AST_ADDR_ACK: assert property (@(posedge link_clk) disable iff (sys_rst)   // RULE2
        state == ST_ADDR && byte_done && addr_hit |=> sda_oe && state == ST_PTR)
        else $error("matching address not acknowledged");
    AST_READ_NAK: assert property (@(posedge link_clk) disable iff (sys_rst)   // RULE1
        state == ST_ADDR && byte_done && shreg[0] |=> !sda_oe && state == ST_SKIP)
        else $error("read request acknowledged");
    // ack starts only after the eighth bit and is let go only at a clock fall, start or stop
    AST_ACK_HOLD: assert property (@(posedge link_clk) disable iff (sys_rst)   // RULE8
        ($rose(sda_oe) |-> $past(bit_cnt) == BYTE_BITS)
        and ($fell(sda_oe) |-> $past(scl_fall) || $past(start_det) || $past(stop_det)))
        else $error("acknowledge dropped early");
    AST_PTR_INC: assert property (@(posedge link_clk) disable iff (sys_rst)   // RULE13
        state == ST_DATA && byte_done && !start_det && !stop_det
        |=> reg_ptr == 8'($past(reg_ptr) + 8'h01) && wr_evt.data == $past(shreg))
        else $error("pointer not advanced on data byte");
    AST_UPDATE_LOAD: assert property (@(posedge mclk) disable iff (sys_rst)   // RULE17
        do_update && !soft_rst |=> active_duty[0] == $past(staged_duty[0])
            && active_ctrl[2] == $past(staged_ctrl[2]))
        else $error("update did not load active set");
    AST_NO_EARLY_LOAD: assert property (@(posedge mclk) disable iff (sys_rst)   // RULE21
        !do_update && !soft_rst |=> $stable(active_duty[2]) && $stable(active_ctrl[2]))
        else $error("active set changed without update");
    AST_SOFT_RESET: assert property (@(posedge mclk) disable iff (sys_rst)   // RULE20
        soft_rst |=> !soft_shutdown_bit && !global_off && staged_duty[2] == DUTY_RST
            && active_duty[2] == DUTY_RST)
        else $error("soft reset left a register set");
    AST_GLOBAL_OFF: assert property (@(posedge mclk) disable iff (sys_rst)   // RULE23
        global_off ##1 global_off |-> led_channel_outputs == 28'h0000000)
        else $error("global off did not blank outputs");
    AST_SHUTDOWN: assert property (@(posedge mclk) disable iff (sys_rst)   // RULE25
        !soft_shutdown_bit ##1 !soft_shutdown_bit |-> led_channel_outputs == 28'h0000000)
        else $error("shutdown did not blank outputs");

    COV_ADDR_ACK: cover property (@(posedge link_clk) disable iff (sys_rst)
        state == ST_ADDR && byte_done && addr_hit);
    COV_DATA_WRITE: cover property (@(posedge mclk) disable iff (sys_rst) wr_fire);
    COV_UPDATE: cover property (@(posedge mclk) disable iff (sys_rst) do_update);
    COV_SOFT_RESET: cover property (@(posedge mclk) disable iff (sys_rst) soft_rst);

endmodule : led_pwm_target

//--- verif/i2c_host_model.sv
/*
 * Behavioural serial bus master that writes to the LED driver target.
 * Assumes the data wire is resolved outside with a pull-up; the model only pulls low.
 */
`timescale 1ns/1ps
module i2c_host_model (
    // serial pins
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda_wire
);
    // ------------------------------------------------------------
    // bus phases: 1300 ns per phase keeps the clock near 385 kHz
    // ------------------------------------------------------------
    localparam int HALF = 1300;
    localparam int QTR  = 650;

    // idle bus: clock high, data released high
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // data falls while clock high
    task automatic start_c();
        sda_pull = 1'b1;
        #QTR scl = 1'b0;
    endtask : start_c

    // data rises while clock high, then bus free time
    task automatic stop_c();
        #QTR sda_pull = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_pull = 1'b0;
        #HALF;
    endtask : stop_c

    // eight bits msb first, changed only while clock low, then the ack pulse
    task automatic put_byte(input logic [7:0] v, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #QTR sda_pull = ~v[i];
            #QTR scl = 1'b1;
            #HALF scl = 1'b0;
        end
        #QTR sda_pull = 1'b0;
        #QTR scl = 1'b1;
        #QTR ack = (sda_wire === 1'b0);
        #QTR scl = 1'b0;
    endtask : put_byte
endmodule : i2c_host_model

//--- verif/tb.sv
/*
 * Self-checking bench for the LED driver target: serial writes, staging, PWM, resets.
 * Assumes the host model drives the bus; the bench owns clocks, strap and shutdown pin.
 */
`timescale 1ns/1ps
module tb;
    import led_drv_pkg::*;
    logic        mclk = 1'b0;
    logic        link_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        hw_shutdown_pin_n = 1'b1;
    logic [1:0]  strap = 2'd0;
    logic        scl;
    logic        sda_pull;
    logic        sda_out;
    logic        sda_oe;
    logic [27:0] led_channel_outputs;
    logic [55:0] current_scale_sel;
    wire         sda_wire = (sda_pull || (sda_oe && sda_out === 1'b0)) ? 1'b0 : 1'b1;
    wire         addr_sel_pin = (strap == 2'd0) ? 1'b0 : (strap == 2'd1) ? 1'b1 : (strap == 2'd2) ? scl : sda_wire;
    int          err_total = 0;
    int          total_checks = 0;
    int          cycles = 0;
    logic [1:0]  a21 [4] = '{2'b00, 2'b11, 2'b01, 2'b10};

    // ------------------------------------------------------------
    // clocks: link clock unrelated in phase to the system clock
    // ------------------------------------------------------------
    initial forever #20 mclk = ~mclk;
    initial begin
        #7;
        forever #32 link_clk = ~link_clk;
    end

    led_pwm_target u_dut (.mclk(mclk), .link_clk(link_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel_pin(addr_sel_pin), .hw_shutdown_pin_n(hw_shutdown_pin_n),
        .led_channel_outputs(led_channel_outputs), .current_scale_sel(current_scale_sel));
    i2c_host_model u_host (.scl(scl), .sda_pull(sda_pull), .sda_wire(sda_wire));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask : check

    // hang guard: whole sequence needs about 44400 cycles, under the 60000 limit
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_total++;
            complete_run();
        end
    end

    // address byte with strap bits and direction zero
    function automatic logic [7:0] adr(input logic [1:0] s);
        return {TGT_ADDR_HI, s, 1'b0};
    endfunction : adr

    // write transfer of n data bytes from pointer p; ok when every byte acked
    task automatic wr(input logic [7:0] p, d0, d1, d2, input int n, output logic ok);
        logic       ak;
        logic [7:0] d [3];
        d = '{d0, d1, d2};
        u_host.start_c();
        u_host.put_byte(adr(a21[strap]), ok);
        u_host.put_byte(p, ak);
        ok &= ak;
        for (int i = 0; i < n; i++) begin
            u_host.put_byte(d[i], ak);
            ok &= ak;
        end
        u_host.stop_c();
        repeat (10) @(negedge mclk);
    endtask : wr

    // address byte only; host abandons the transfer with a stop
    task automatic probe(input logic [7:0] a, output logic ack);
        u_host.start_c();
        u_host.put_byte(a, ack);
        u_host.stop_c();
    endtask : probe

    // on-time of one channel over one full 256-count period
    task automatic on_count(input int ch, output int n);
        n = 0;
        repeat (256) begin
            @(negedge mclk);
            if (led_channel_outputs[ch] === 1'b1) n++;
        end
    endtask : on_count

    task automatic t_reset_defaults();
        check(led_channel_outputs === 28'h0, "leds not off after reset");
        check(current_scale_sel === 56'h0, "scale not default after reset");
    endtask : t_reset_defaults

    task automatic t_address();
        logic ok;
        for (int m = 0; m < 4; m++) begin
            @(negedge mclk) strap = m[1:0];
            repeat (10) @(negedge mclk); // strap must pass its filter before the start
            wr(OFS_GLOBAL, 8'h00, 8'h00, 8'h00, 1, ok);
            check(ok, "strap address not acknowledged");
            probe(adr(a21[m] ^ 2'b01), ok);
            check(!ok, "wrong strap bits acknowledged");
            probe(8'h80 | adr(a21[m]), ok);
            check(!ok, "wrong upper bits acknowledged");
        end
        probe(adr(a21[strap]) | 8'h01, ok);
        check(!ok, "read direction acknowledged");
    endtask : t_address

    task automatic t_staging();
        logic ok;
        int   n;
        wr(OFS_SHUTDOWN, 8'h01, 8'h00, 8'h00, 1, ok);
        wr(OFS_DUTY_BASE, 8'h80, 8'h00, 8'hff, 3, ok);
        wr(OFS_CTRL_BASE, 8'h03, 8'h01, 8'h07, 3, ok);
        check(ok, "multi-byte write not acknowledged");
        wr(OFS_UPDATE, 8'h01, 8'h00, 8'h00, 1, ok);
        check(current_scale_sel === 56'h0, "staged values active too early");
        on_count(0, n);
        check(n == 0, "staged duty active too early");
        wr(OFS_UPDATE, TRIGGER_VALUE, 8'h00, 8'h00, 1, ok);
        check(current_scale_sel === 56'h31, "scale after update");
        on_count(0, n);
        check(n == 128, "channel 1 duty count");
        on_count(1, n);
        check(n == 0, "channel 2 duty count");
        on_count(2, n);
        check(n == 255, "channel 3 duty count");
    endtask : t_staging

    task automatic t_gating();
        logic ok;
        int   n;
        wr(OFS_GLOBAL, 8'h01, 8'h00, 8'h00, 1, ok);
        on_count(2, n);
        check(n == 0, "global off not applied");
        wr(OFS_GLOBAL, 8'h00, 8'h00, 8'h00, 1, ok);
        @(negedge mclk) hw_shutdown_pin_n = 1'b0;
        repeat (4) @(negedge mclk);
        on_count(2, n);
        check(n == 0, "hardware shutdown not applied");
        @(negedge mclk) hw_shutdown_pin_n = 1'b1;
        repeat (4) @(negedge mclk);
        on_count(2, n);
        check(n == 255, "channel did not resume");
        wr(OFS_SHUTDOWN, 8'h00, 8'h00, 8'h00, 1, ok);
        on_count(2, n);
        check(n == 0, "software shutdown not applied");
    endtask : t_gating

    task automatic t_soft_reset();
        logic ok;
        int   n;
        wr(OFS_SHUTDOWN, 8'h01, 8'h00, 8'h00, 1, ok);
        wr(OFS_RESET, 8'h5a, 8'h00, 8'h00, 1, ok);
        check(current_scale_sel === 56'h31, "nonzero reset write acted");
        wr(OFS_RESET, TRIGGER_VALUE, 8'h00, 8'h00, 1, ok);
        check(current_scale_sel === 56'h0, "soft reset left scale");
        wr(OFS_SHUTDOWN, 8'h01, 8'h00, 8'h00, 1, ok);
        wr(8'(OFS_CTRL_BASE + 8'h02), 8'h05, 8'h00, 8'h00, 1, ok);
        wr(OFS_UPDATE, TRIGGER_VALUE, 8'h00, 8'h00, 1, ok);
        check(current_scale_sel === 56'h20, "staged values survived reset");
        on_count(2, n);
        check(n == 0, "duty survived soft reset");
    endtask : t_soft_reset

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (8) @(negedge mclk);
        t_reset_defaults();
        t_address();
        t_staging();
        t_gating();
        t_soft_reset();
        complete_run();
    end
endmodule : tb
